/* File: rtl/mpgpio_top.sv */
// Seven-port pin block: data latches, pin modes, pull-ups, alternate functions, edge interrupts.
// Assumes a CPU register port sampled on clk_i and pins that are asynchronous to it.
//
// Contract
// - Port zero data register at E4H, read and written directly.
// - Port one data register at E5H, read and written directly.
// - Port two data register at E6H, read and written directly.
// - Port three data register at E7H, read and written directly.
// - Port four data register at E8H, read and written directly.
// - Port five data register at E9H, read and written directly.
// - Port six data register at EAH; pins may carry LCD commons zero to three.
// - Port zero control resets to zero; selects input, push-pull, open-drain, alternate.
// - Port four has upper and lower control registers, both reset to inputs.
// - Port zero pins four and five are push-pull outputs only.
// - Port zero pins zero to three carry timer, timer clock, buzzer, interrupt.
// - Enabled selected edge on port zero sets pending bit, pulls request low.
// - Port zero enable at EDH, pending D6H low nibble, edge at EEH.
// - Port one enable at F1H, pending D6H high nibble, edge at F2H.
// - Port three enable at F7H, pending D7H bits five/four, edge at F8H.
// - Enabled selected edge on port three sets pending bit, pulls request low.
// - Port zero pull-ups enabled per pin through ECH.
// - Port three: input with or without pull-up, high-impedance input, push-pull, open-drain.
// - Port five pins four to seven carry LCD segments 16-19 or commons 4-7.
`timescale 1ns/1ps
module mpgpio_top
  import mpgpio_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  // CPU register port
  input  wire mpgpio_req_s         req_i,
  output logic [7:0]               rdata_o,
  // Pins
  input  wire logic [NUM_PINS-1:0] pin_i,
  output mpgpio_pad_s              pad_o,
  // Peripherals sharing pins
  input  wire logic                timer_match_out_i,
  input  wire logic                buzzer_out_i,
  input  wire mpgpio_lcd_s         lcd_i,
  output logic                     timer_ext_clock_in_o,
  // Interrupt request, low while any pending bit is set
  output logic                     irq_b_o
);

  logic [8*WIN_REGS-1:0] reg_flat;
  logic [2*NUM_PINS-1:0] mode_v;
  logic [NUM_PINS-1:0]   latch_v;
  logic [NUM_PINS-1:0]   s1_q, s2_q, s3_q, lvl_q;
  logic [NUM_PINS-1:0]   rd_bits;
  logic [NUM_PINS-1:0]   alt_val;
  logic [NUM_PINS-1:0]   pu_all;
  logic [SETTLE_CYC-1:0] settle_q;
  logic [IRQ_A_W-1:0]    p0_prev_q, p1_prev_q, p0_ev, p1_ev;
  logic [IRQ_B_W-1:0]    p3_prev_q, p3_ev;
  logic [7:0]            pend_a_q, pend_a_d;
  logic [IRQ_B_W-1:0]    pend_b_q, pend_b_d;
  logic [7:0]            rd_val;
  logic [7:0]            rdata_q;
  mpgpio_pad_s           pad_q, pad_d;
  logic                  irq_b_q;
  logic                  tclk_q;
  logic                  win_hit;

  function automatic logic [7:0] rv(input logic [8*WIN_REGS-1:0] f, input logic [7:0] a);
    return f[{a[4:0], 3'b000} +: 8];
  endfunction : rv

  function automatic logic [IRQ_A_W-1:0] edge_ev(input logic [IRQ_A_W-1:0] cur,
                                                 input logic [IRQ_A_W-1:0] prev,
                                                 input logic [7:0] sel,
                                                 input logic [7:0] ie);
    logic [IRQ_A_W-1:0] r;
    r = '0;
    for (int i = 0; i < IRQ_A_W; i++) begin
      if (ie[i] && cur[i] != prev[i] && cur[i] == (sel[i] == EDGE_RISE)) begin
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction : edge_ev

  assign win_hit = req_i.addr[7:5] == WIN_TOP;

  // Register window E0H-FFH; unimplemented bits never store
  for (genvar r = 0; r < WIN_REGS; r++) begin : g_reg
    logic [7:0] q;
    always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
        q <= REG_RESET;
      end else if (req_i.wr && win_hit && req_i.addr[4:0] == 5'(r)) begin
        q <= req_i.wdata & reg_mask({WIN_TOP, 5'(r)});
      end
    end
    assign reg_flat[8*r +: 8] = q;
  end

  // Per-pin mode and latch gathered from the port registers
  for (genvar k = 0; k < NUM_PORTS; k++) begin : g_port
    for (genvar b = 0; b < PORT_W[k]; b++) begin : g_pin
      localparam int         P  = PORT_LSB[k] + b;
      localparam logic [7:0] CA = ctl_addr(k, b);
      localparam logic [7:0] DA = ADDR_DATA_BASE + 8'(k);
      localparam int         SH = 2 * (b % CTL_PINS_PER_REG);
      if (k == 0 && b >= P0_CTL_PINS) begin : g_fixed
        assign mode_v[2*P +: 2] = MODE_PP;
      end else begin : g_cfg
        assign mode_v[2*P +: 2] = reg_flat[8*CA[4:0] + SH +: 2];
      end
      assign latch_v[P] = reg_flat[8*DA[4:0] + b];
    end
  end

  // Three-stage pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
    end
  end

  // Edges are ignored until the synchroniser holds real pin levels, avoiding false events
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      settle_q <= '0;
    end else begin
      settle_q <= {settle_q[SETTLE_CYC-2:0], 1'b1};
    end
  end

  // Alternate sources; port five high nibble picks commons or segments
  assign alt_val = {lcd_i.com[3:0],
                    lcd_i.com_sel ? lcd_i.com[7:4] : lcd_i.lcd_segment_line[19:16],
                    lcd_i.lcd_segment_line[15:4], 2'b00, 2'b00, lcd_i.lcd_segment_line[1:0], 4'h0, 2'b00,
                    1'b0, buzzer_out_i, 1'b0, timer_match_out_i};

  assign pu_all = {20'h0_0000, reg_flat[8*ADDR_P3_PU[4:0] +: 2], reg_flat[8*ADDR_P2_PU[4:0] +: 4],
                   reg_flat[8*ADDR_P1_PU[4:0] +: 4], 2'b00,
                   reg_flat[8*ADDR_P0_PU[4:0] +: 4]};

  // Pad drive: open-drain only sinks, port three alternate code is high-impedance input
  always_comb begin
    pad_d = '0;
    rd_bits = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      unique case (mpgpio_mode_e'(mode_v[2*i +: 2]))
        MODE_IN: begin
          pad_d.pull[i] = pu_all[i];
          rd_bits[i] = lvl_q[i];
        end
        MODE_OD: begin
          pad_d.oe[i] = ~latch_v[i];
          rd_bits[i] = latch_v[i];
        end
        MODE_PP: begin
          pad_d.oe[i] = 1'b1;
          pad_d.out[i] = latch_v[i];
          rd_bits[i] = latch_v[i];
        end
        MODE_ALT: begin
          if (HIZ_MASK[i]) begin
            rd_bits[i] = 1'b0;
          end else begin
            pad_d.oe[i] = ALT_DRV_MASK[i];
            pad_d.out[i] = ALT_DRV_MASK[i] & alt_val[i];
            rd_bits[i] = lvl_q[i];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pad_q <= '0;
      tclk_q <= 1'b0;
    end else begin
      pad_q <= pad_d;
      tclk_q <= (mode_v[2*PIN_TMR_CLK +: 2] == MODE_ALT) & lvl_q[PIN_TMR_CLK];
    end
  end

  // Edge events on the interrupt-capable pins
  always_comb begin
    p0_ev = '0;
    p1_ev = '0;
    p3_ev = '0;
    if (settle_q[SETTLE_CYC-1]) begin
      p0_ev = edge_ev(lvl_q[P0_IRQ_LSB +: IRQ_A_W], p0_prev_q,
                      rv(reg_flat, ADDR_P0_EDGE), rv(reg_flat, ADDR_P0_IE));
      p1_ev = edge_ev(lvl_q[P1_IRQ_LSB +: IRQ_A_W], p1_prev_q,
                      rv(reg_flat, ADDR_P1_EDGE), rv(reg_flat, ADDR_P1_IE));
      p3_ev = IRQ_B_W'(edge_ev({2'b00, lvl_q[P3_IRQ_LSB +: IRQ_B_W]}, {2'b00, p3_prev_q},
                      rv(reg_flat, ADDR_P3_EDGE), rv(reg_flat, ADDR_P3_IE)));
    end
  end

  // A set in the same cycle as a clearing write wins over the clear
  always_comb begin
    pend_a_d = pend_a_q;
    pend_b_d = pend_b_q;
    if (req_i.wr && req_i.addr == ADDR_PEND_A) begin
      pend_a_d = pend_a_q & req_i.wdata;
    end
    if (req_i.wr && req_i.addr == ADDR_PEND_B) begin
      pend_b_d = pend_b_q & req_i.wdata[PEND_B_LSB +: IRQ_B_W];
    end
    pend_a_d = pend_a_d | {p1_ev, p0_ev};
    pend_b_d = pend_b_d | p3_ev;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      p0_prev_q <= '0;
      p1_prev_q <= '0;
      p3_prev_q <= '0;
      pend_a_q <= '0;
      pend_b_q <= '0;
      irq_b_q <= 1'b1;
    end else begin
      p0_prev_q <= lvl_q[P0_IRQ_LSB +: IRQ_A_W];
      p1_prev_q <= lvl_q[P1_IRQ_LSB +: IRQ_A_W];
      p3_prev_q <= lvl_q[P3_IRQ_LSB +: IRQ_B_W];
      pend_a_q <= pend_a_d;
      pend_b_q <= pend_b_d;
      irq_b_q <= ~(|pend_a_d | |pend_b_d);
    end
  end

  // Read path; data ports return per-pin level or latch, zero on port three high-impedance pins
  always_comb begin
    rd_val = '0;
    if (req_i.addr == ADDR_PEND_A) begin
      rd_val = pend_a_q;
    end else if (req_i.addr == ADDR_PEND_B) begin
      rd_val = 8'(pend_b_q) << PEND_B_LSB;
    end else if (win_hit) begin
      rd_val = rv(reg_flat, req_i.addr);
      for (int k = 0; k < NUM_PORTS; k++) begin
        if (req_i.addr == ADDR_DATA_BASE + 8'(k)) begin
          rd_val = 8'(rd_bits >> PORT_LSB[k]) & reg_mask(req_i.addr);
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_q <= '0;
    end else if (req_i.rd) begin
      rdata_q <= rd_val;
    end
  end

  assign rdata_o = rdata_q;
  assign pad_o = pad_q;
  assign irq_b_o = irq_b_q;
  assign timer_ext_clock_in_o = tclk_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  chk_data_write: assert property (
    req_i.wr && req_i.addr == ADDR_DATA_BASE |=>
      rv(reg_flat, ADDR_DATA_BASE) == ($past(req_i.wdata) & MASK_SIX))
    else $error("port zero data write not stored");

  chk_ctl_reset: assert property (@(posedge clk_i) disable iff (1'b0)
    !rst_b_i |=> rv(reg_flat, ADDR_P0_CTL) == REG_RESET && pad_o.oe[3:0] == '0)
    else $error("port zero control not cleared by reset");

  chk_p4_reset: assert property (@(posedge clk_i) disable iff (1'b0)
    !rst_b_i |=> rv(reg_flat, ADDR_P4_CTL_HI) == REG_RESET && rv(reg_flat, ADDR_P4_CTL_LO) == REG_RESET)
    else $error("port four control not cleared by reset");

  chk_p0_high_push: assert property (
    $past(rst_b_i) |-> pad_o.oe[5:4] == 2'b11 && pad_o.pull[5:4] == 2'b00)
    else $error("port zero high pins not push-pull");

  chk_timer_alt: assert property (
    mode_v[2*PIN_TMR_OUT +: 2] == MODE_ALT |=>
      pad_o.oe[PIN_TMR_OUT] && pad_o.out[PIN_TMR_OUT] == $past(timer_match_out_i))
    else $error("timer match output not routed");

  chk_pend_set: assert property (
    p0_ev != '0 |=> (pend_a_q[3:0] & $past(p0_ev)) == $past(p0_ev) && !irq_b_o)
    else $error("port zero edge did not set pending");

  chk_pend_b_set: assert property (
    p3_ev != '0 |=> (pend_b_q & $past(p3_ev)) == $past(p3_ev) && !irq_b_o)
    else $error("port three edge did not set pending");

  chk_pend_clear: assert property (
    req_i.wr && req_i.addr == ADDR_PEND_A && !req_i.wdata[0] && !p0_ev[0] |=> !pend_a_q[0])
    else $error("pending bit not cleared by zero write");

  chk_irq_idle: assert property (
    pend_a_q == '0 && pend_b_q == '0 |-> irq_b_o)
    else $error("request low without pending bit");

  chk_lcd_com: assert property (
    mode_v[2*28 +: 2] == MODE_ALT && lcd_i.com_sel |=> pad_o.out[28] == $past(lcd_i.com[4]))
    else $error("port five common line not routed");

  chk_hiz_input: assert property (
    mode_v[2*P3_IRQ_LSB +: 2] == MODE_ALT |=> !pad_o.oe[P3_IRQ_LSB] && !pad_o.pull[P3_IRQ_LSB])
    else $error("port three high-impedance input driven");

  chk_readback: assert property (
    req_i.rd && req_i.addr == ADDR_DATA_BASE + 8'h04 && rv(reg_flat, ADDR_P4_CTL_LO) == '0
      && rv(reg_flat, ADDR_P4_CTL_HI) == '0 |=> rdata_o == $past(lvl_q[23:16]))
    else $error("input port read not pin level");

  cov_irq_fall: cover property ($fell(irq_b_o));
  cov_pend_clear: cover property (pend_a_q != '0 ##1 pend_a_q == '0);
  cov_com_route: cover property (pad_o.oe[PIN_COM0] && pad_q.out[PIN_COM0]);

endmodule : mpgpio_top

/* File: rtl/mpgpio_pkg.sv */
// Constants, register map and carrier types of the multi-port pin block.
// Assumes an 8-bit register port with page-0 byte addresses.
package mpgpio_pkg;

  localparam int NUM_PINS  = 36;
  localparam int NUM_PORTS = 7;
  localparam int WIN_REGS  = 32;

  // Pin position and width of each port in the flat pin vector
  localparam int PORT_LSB [NUM_PORTS] = '{0, 6, 10, 14, 16, 24, 32};
  localparam int PORT_W   [NUM_PORTS] = '{6, 4, 4, 2, 8, 8, 4};
  localparam int P0_CTL_PINS = 4;
  localparam int CTL_PINS_PER_REG = 4;

  // Register offsets
  localparam logic [7:0] ADDR_PEND_A    = 8'hD6;
  localparam logic [7:0] ADDR_PEND_B    = 8'hD7;
  localparam logic [7:0] ADDR_DATA_BASE = 8'hE4;
  localparam logic [7:0] ADDR_DATA_LAST = 8'hEA;
  localparam logic [7:0] ADDR_P0_CTL    = 8'hEB;
  localparam logic [7:0] ADDR_P0_PU     = 8'hEC;
  localparam logic [7:0] ADDR_P0_IE     = 8'hED;
  localparam logic [7:0] ADDR_P0_EDGE   = 8'hEE;
  localparam logic [7:0] ADDR_P1_CTL    = 8'hEF;
  localparam logic [7:0] ADDR_P1_PU     = 8'hF0;
  localparam logic [7:0] ADDR_P1_IE     = 8'hF1;
  localparam logic [7:0] ADDR_P1_EDGE   = 8'hF2;
  localparam logic [7:0] ADDR_P2_CTL    = 8'hF3;
  localparam logic [7:0] ADDR_P2_PU     = 8'hF4;
  localparam logic [7:0] ADDR_P3_CTL    = 8'hF5;
  localparam logic [7:0] ADDR_P3_PU     = 8'hF6;
  localparam logic [7:0] ADDR_P3_IE     = 8'hF7;
  localparam logic [7:0] ADDR_P3_EDGE   = 8'hF8;
  localparam logic [7:0] ADDR_P4_CTL_HI = 8'hF9;
  localparam logic [7:0] ADDR_P4_CTL_LO = 8'hFA;
  localparam logic [7:0] ADDR_P5_CTL_HI = 8'hFB;
  localparam logic [7:0] ADDR_P5_CTL_LO = 8'hFC;
  localparam logic [7:0] ADDR_P6_CTL    = 8'hFD;
  localparam logic [2:0] WIN_TOP        = 3'h7;

  // Implemented bits of each register
  localparam logic [7:0] MASK_NONE  = 8'h00;
  localparam logic [7:0] MASK_FULL  = 8'hFF;
  localparam logic [7:0] MASK_NIB   = 8'h0F;
  localparam logic [7:0] MASK_SIX   = 8'h3F;
  localparam logic [7:0] MASK_TWO   = 8'h03;
  localparam logic [7:0] REG_RESET  = 8'h00;

  // Pending bit placement and interrupt source pins
  localparam int PEND_B_LSB = 4;
  localparam int P0_IRQ_LSB = 0;
  localparam int P1_IRQ_LSB = 6;
  localparam int P3_IRQ_LSB = 14;
  localparam int IRQ_A_W    = 4;
  localparam int IRQ_B_W    = 2;
  localparam logic EDGE_RISE = 1'b1;

  // Alternate-function pins
  localparam int PIN_TMR_OUT = 0;
  localparam int PIN_TMR_CLK = 1;
  localparam int PIN_COM0    = 32;
  localparam logic [NUM_PINS-1:0] ALT_DRV_MASK = 36'hF_FFFF_0C05;
  localparam logic [NUM_PINS-1:0] HIZ_MASK     = 36'h0_0000_C000;
  localparam int SETTLE_CYC = 4;

  typedef enum logic [1:0] {MODE_IN, MODE_OD, MODE_PP, MODE_ALT} mpgpio_mode_e;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mpgpio_req_s;

  typedef struct packed {
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] oe;
    logic [NUM_PINS-1:0] pull;
  } mpgpio_pad_s;

  typedef struct packed {
    logic [19:0] lcd_segment_line;
    logic [7:0]  com;
    logic        com_sel;
  } mpgpio_lcd_s;

  function automatic logic [7:0] reg_mask(input logic [7:0] a);
    unique case (a)
      ADDR_DATA_BASE: return MASK_SIX;
      8'hE5, 8'hE6, ADDR_DATA_LAST: return MASK_NIB;
      8'hE7: return MASK_TWO;
      8'hE8, 8'hE9: return MASK_FULL;
      ADDR_P0_CTL, ADDR_P1_CTL, ADDR_P2_CTL, ADDR_P4_CTL_HI, ADDR_P4_CTL_LO,
      ADDR_P5_CTL_HI, ADDR_P5_CTL_LO, ADDR_P6_CTL: return MASK_FULL;
      ADDR_P0_PU, ADDR_P0_IE, ADDR_P0_EDGE, ADDR_P1_PU, ADDR_P1_IE, ADDR_P1_EDGE,
      ADDR_P2_PU, ADDR_P3_CTL: return MASK_NIB;
      ADDR_P3_PU, ADDR_P3_IE, ADDR_P3_EDGE: return MASK_TWO;
      default: return MASK_NONE;
    endcase
  endfunction : reg_mask

  function automatic logic [7:0] ctl_addr(input int k, input int b);
    unique case (k)
      0: return ADDR_P0_CTL;
      1: return ADDR_P1_CTL;
      2: return ADDR_P2_CTL;
      3: return ADDR_P3_CTL;
      4: return (b < CTL_PINS_PER_REG) ? ADDR_P4_CTL_LO : ADDR_P4_CTL_HI;
      5: return (b < CTL_PINS_PER_REG) ? ADDR_P5_CTL_LO : ADDR_P5_CTL_HI;
      default: return ADDR_P6_CTL;
    endcase
  endfunction : ctl_addr

endpackage : mpgpio_pkg

/* File: verification/mpgpio_pins_model.sv */
// Board-side model of the 36 pads: resolves each pin from the block drive,
// the board drive and the pull-up. Assumes the bench sets board levels.
`timescale 1ns/1ps
module mpgpio_pins_model
  import mpgpio_pkg::*;
(
  // Clock
  input  wire logic                clk_i,
  // Block side
  input  wire mpgpio_pad_s         pad_i,
  output logic [NUM_PINS-1:0]      pin_o,
  // Board side
  input  wire logic [NUM_PINS-1:0] ext_lvl_i,
  input  wire logic [NUM_PINS-1:0] ext_en_i
);
  logic [NUM_PINS-1:0] float_q = '0;

  // Undriven, unpulled pins wander so a missing pull-up cannot pass by luck
  always @(posedge clk_i) begin
    float_q <= ~float_q;
  end

  // Open-drain release shows up here as oe low
  always_comb begin
    pin_o = (pad_i.oe & pad_i.out)
          | (~pad_i.oe & ext_en_i & ext_lvl_i)
          | (~pad_i.oe & ~ext_en_i & (pad_i.pull | float_q));
  end
endmodule : mpgpio_pins_model

/* File: verification/mpgpio_top_tb.sv */
// Self-checking bench of the pin block: register port, pin modes, alternates, edge interrupts.
// Assumes the pad model on the far side; reads are scored through an expectation queue.
`timescale 1ns/1ps
`define CHK_EQ(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t ns: got %h expected %h", $time, (g), (e)); end end
module mpgpio_top_tb
  import mpgpio_pkg::*;
;
  localparam logic [7:0] CM [19] = '{8'hFF, 8'h0F, 8'h0F, 8'h0F, 8'hFF, 8'h0F, 8'h0F,
    8'h0F, 8'hFF, 8'h0F, 8'h0F, 8'h03, 8'h03, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] DM [7] = '{8'h3F, 8'h0F, 8'h0F, 8'h03, 8'hFF, 8'hFF, 8'h0F};

  logic                clk_i = 1'b0;
  logic                rst_b_i = 1'b0;
  mpgpio_req_s         req = '0;
  logic [7:0]          rdata_o;
  logic [NUM_PINS-1:0] pin_i;
  mpgpio_pad_s         pad_o;
  logic                tmo = 1'b0;
  logic                buzzer_out = 1'b0;
  mpgpio_lcd_s         lcd = '0;
  logic                tclk_o;
  logic                irq_b_o;
  logic [NUM_PINS-1:0] ext_lvl = '0;
  logic [NUM_PINS-1:0] ext_en = '1;
  logic [7:0]          exp_q [$];
  logic [7:0]          exp_v;
  logic [7:0]          lat [7];
  logic                rd_seen = 1'b0;
  logic [31:0]         lfsr_q = 32'd84353;
  int                  bad_count = 0;
  int                  samples_checked = 0;

  always #25 clk_i = ~clk_i;

  mpgpio_top mpgpio_top_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req), .rdata_o(rdata_o), .pin_i(pin_i),
    .pad_o(pad_o), .timer_match_out_i(tmo), .buzzer_out_i(buzzer_out), .lcd_i(lcd),
    .timer_ext_clock_in_o(tclk_o), .irq_b_o(irq_b_o));

  mpgpio_pins_model mpgpio_pins_model_inst (
    .clk_i(clk_i), .pad_i(pad_o), .pin_o(pin_i), .ext_lvl_i(ext_lvl), .ext_en_i(ext_en));

  // Scoreboard: read data lands the cycle after the strobe edge
  always @(posedge clk_i) rd_seen <= req.rd;
  always @(negedge clk_i) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("[FAIL] %0t ns: read data with no expectation", $time);
      end else begin
        // Pop once: the compare macro names its expected value twice
        exp_v = exp_q.pop_front();
        `CHK_EQ(rdata_o, exp_v)
      end
    end
  end

  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_step

  task automatic rnd(output logic [31:0] v);
    lfsr_q = lfsr_step(lfsr_q);
    v = lfsr_q;
  endtask : rnd

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req.wr = 1'b1; req.addr = a; req.wdata = d;
    @(negedge clk_i);
    req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i);
    req.rd = 1'b1; req.addr = a; exp_q.push_back(e);
    @(negedge clk_i);
    req.rd = 1'b0;
  endtask : rd

  task automatic do_reset();
    rst_b_i = 1'b0;
    cyc(8);
    rst_b_i = 1'b1;
    cyc(6);
  endtask : do_reset

  task automatic print_verdict();
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // Bounded wait on the request line; a hang counts against the run
  task automatic wait_irq(input logic lvl);
    int n;
    for (n = 0; n < 12 && irq_b_o !== lvl; n++) @(negedge clk_i);
    if (irq_b_o !== lvl) begin
      bad_count++;
      $display("[FAIL] %0t ns: request line never reached %b", $time, lvl);
      print_verdict();
    end
  endtask : wait_irq

  task automatic all_ctl(input logic [7:0] v);
    foreach (CM[i]) if (CM[i] == 8'hFF || i == 10) wr(8'hEB + 8'(i), v);
  endtask : all_ctl

  initial begin
    logic [31:0] r;
    logic [35:0] x;
    logic [7:0]  ie_a;
    logic [7:0]  e;
    int          p;
    int          pb;
    do_reset();
    // Reset values, refused and unmapped places
    foreach (CM[i]) rd(8'hEB + 8'(i), 8'h00);
    rd(8'hD6, 8'h00);
    rd(8'hD7, 8'h00);
    rnd(r);
    wr(8'hFF, r[7:0]);
    rd(8'hFF, 8'h00);
    // Random write and read-back of every configuration register
    foreach (CM[i]) begin
      rnd(r);
      wr(8'hEB + 8'(i), r[7:0]);
      rd(8'hEB + 8'(i), r[7:0] & CM[i]);
    end
    foreach (CM[i]) wr(8'hEB + 8'(i), 8'h00);
    cyc(10);
    wr(8'hD6, 8'h00);
    wr(8'hD7, 8'h00);
    rd(8'hD6, 8'h00);
    rd(8'hD7, 8'h00);
    // Push-pull outputs: latch reads back and reaches the pads
    all_ctl(8'hAA);
    for (int k = 0; k < 7; k++) begin
      rnd(r);
      lat[k] = r[7:0] & DM[k];
      wr(ADDR_DATA_BASE + 8'(k), r[7:0]);
      rd(ADDR_DATA_BASE + 8'(k), lat[k]);
      cyc(3);
      `CHK_EQ(8'((pad_o.out >> PORT_LSB[k]) & 36'(DM[k])), lat[k])
      `CHK_EQ(8'((pad_o.oe >> PORT_LSB[k]) & 36'(DM[k])), DM[k])
    end
    // Open-drain drives low only where the latch is zero
    wr(8'hEB, 8'h55);
    wr(8'hE4, 8'h35);
    cyc(3);
    `CHK_EQ(pad_o.oe[3:0], 4'b1010)
    `CHK_EQ(pad_o.out[3:0], 4'b0000)
    `CHK_EQ(pad_o.oe[5:4], 2'b11)
    lat[0] = 8'h35;
    // Inputs read the pin level, pins 4 and 5 of port zero still read their latch
    all_ctl(8'h00);
    rnd(r);
    ext_lvl = {r[3:0], r};
    cyc(6);
    for (int k = 0; k < 7; k++) begin
      e = 8'((ext_lvl >> PORT_LSB[k]) & 36'(DM[k]));
      if (k == 0) e[5:4] = lat[0][5:4];
      rd(ADDR_DATA_BASE + 8'(k), e);
    end
    // Pull-ups on port zero, a floating pin then reads high
    wr(8'hEC, 8'h0F);
    ext_en[3:0] = 4'h0;
    cyc(6);
    `CHK_EQ(pad_o.pull[3:0], 4'hF)
    rd(8'hE4, {2'b00, lat[0][5:4], 4'hF});
    ext_en = '1;
    wr(8'hEC, 8'h00);
    // Port three: pull-up input, then high-impedance input
    wr(8'hF6, 8'h03);
    cyc(3);
    `CHK_EQ(pad_o.pull[15:14], 2'b11)
    wr(8'hF5, 8'h0F);
    cyc(4);
    `CHK_EQ(pad_o.pull[15:14], 2'b00)
    `CHK_EQ(pad_o.oe[15:14], 2'b00)
    rd(8'hE7, 8'h00);
    wr(8'hF5, 8'h00);
    wr(8'hF6, 8'h00);
    // Alternate functions; the peripherals are taken as already enabled
    wr(8'hEB, 8'hFF);
    wr(8'hFD, 8'hFF);
    wr(8'hFB, 8'hFF);
    for (int t = 0; t < 2; t++) begin
      rnd(r);
      tmo = r[0];
      buzzer_out = r[1];
      ext_lvl[1] = r[2];
      lcd = {r[19:0], r[27:20], 1'(t)};
      cyc(6);
      `CHK_EQ(pad_o.out[0], tmo)
      `CHK_EQ(pad_o.out[2], buzzer_out)
      `CHK_EQ(tclk_o, r[2])
      `CHK_EQ(pad_o.out[35:32], lcd.com[3:0])
      `CHK_EQ(pad_o.out[31:28], (t == 1) ? lcd.com[7:4] : lcd.lcd_segment_line[19:16])
    end
    all_ctl(8'h00);
    ext_lvl = '0;
    cyc(8);
    // Edge interrupts on every source pin, falling and rising selected on alternate pins
    for (int i = 0; i < 10; i++) begin
      p = (i < 4) ? i : (i < 8) ? P1_IRQ_LSB + i - 4 : P3_IRQ_LSB + i - 8;
      ie_a = (i < 4) ? 8'hED : (i < 8) ? 8'hF1 : 8'hF7;
      pb = (i < 8) ? i : i - 4;
      x = 36'(1) << ((i < 4) ? i : (i < 8) ? i - 4 : i - 8);
      wr(ie_a + 8'h01, 8'(x) & {8{i[0]}});
      ext_lvl[p] = ~i[0];
      cyc(8);
      wr(ie_a, 8'(x));
      cyc(8);
      `CHK_EQ(irq_b_o, 1'b1)
      ext_lvl[p] = i[0];
      wait_irq(1'b0);
      rd((i < 8) ? 8'hD6 : 8'hD7, 8'(1 << pb));
      wr((i < 8) ? 8'hD6 : 8'hD7, ~8'(1 << pb));
      cyc(2);
      `CHK_EQ(irq_b_o, 1'b1)
      ext_lvl[p] = ~i[0];
      cyc(8);
      `CHK_EQ(irq_b_o, 1'b1)
      wr(ie_a, 8'h00);
    end
    // Disabled pin: an edge leaves no pending bit
    ext_lvl[0] = ~ext_lvl[0];
    cyc(8);
    `CHK_EQ(irq_b_o, 1'b1)
    rd(8'hD6, 8'h00);
    // Second reset mid-run
    wr(8'hFA, 8'hAA);
    do_reset();
    rd(8'hFA, 8'h00);
    rd(8'hEB, 8'h00);
    cyc(4);
    print_verdict();
  end
endmodule : mpgpio_top_tb
